/* logic/crf_pkg.sv */
// crf_pkg: constants, field positions and types of the cpu state block.
// assumes one clock (mclk, 100 MHz) and a synchronous active-low reset.
package crf_pkg;
    localparam int          GPR_COUNT   = 8;
    localparam logic [2:0]  SP_IDX      = 3'h7;
    localparam int          UPPER_LSB   = 16;
    localparam int          HIGH_LSB    = 8;
    // condition flag bit positions
    localparam int          CCR_I       = 7;
    localparam int          CCR_UI      = 6;
    localparam int          CCR_H       = 5;
    localparam int          CCR_U       = 4;
    localparam int          CCR_N       = 3;
    localparam int          CCR_Z       = 2;
    localparam int          CCR_V       = 1;
    localparam int          CCR_C       = 0;
    localparam logic [7:0]  CCR_RESET   = 8'h80;
    localparam logic [31:0] GPR_RESET   = 32'h0000_0000;
    localparam logic [23:0] PC_RESET    = 24'h00_0000;
    localparam logic [23:0] PC_STEP     = 24'h00_0002;
    localparam logic [31:0] SP_STEP     = 32'h0000_0002;
    localparam logic [15:0] RESET_VEC   = 16'h0000;
    // state counts minus one, loaded when an operation starts
    localparam logic [4:0]  CNT_ADDSUB  = 5'h01;
    localparam logic [4:0]  CNT_MD_S    = 5'h0d;
    localparam logic [4:0]  CNT_MD_L    = 5'h15;
    typedef enum logic [2:0] {
        V_LONG, V_UPPER, V_LOWER, V_HIGH, V_LOW
    } crf_view_t;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;
    typedef enum logic [3:0] {
        OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG,
        OP_MUL8, OP_DIV8, OP_MUL16, OP_DIV16
    } crf_alu_op_t;
    typedef enum logic [2:0] {
        FLAGS_KEEP, LOAD_FLAGS_OP, AND_FLAGS_OP, OR_FLAGS_OP, XOR_FLAGS_OP
    } crf_flag_op_t;
    typedef enum logic {ST_VECTOR, ST_RUN} crf_state_t;
endpackage : crf_pkg

/* logic/crf_gpr_if.sv */
// crf_gpr_if: link between the core and its general register store.
// assumes both ends run on mclk; read data arrive one cycle late.
interface crf_gpr_if;
    import crf_pkg::*;
    logic [2:0]  rd_a_idx;
    crf_view_t   rd_a_view;
    logic [31:0] rd_a_data;
    logic [2:0]  rd_b_idx;
    crf_view_t   rd_b_view;
    logic [31:0] rd_b_data;
    logic        wr_en;
    logic [2:0]  wr_idx;
    crf_view_t   wr_view;
    logic [31:0] wr_data;
    logic [31:0] sp_word;
    modport mem (input rd_a_idx, rd_a_view, rd_b_idx, rd_b_view,
                 input wr_en, wr_idx, wr_view, wr_data,
                 output rd_a_data, rd_b_data, sp_word);
    modport core (output rd_a_idx, rd_a_view, rd_b_idx, rd_b_view,
                  output wr_en, wr_idx, wr_view, wr_data,
                  input rd_a_data, rd_b_data, sp_word);
endinterface : crf_gpr_if

/* logic/crf_gpr_mem.sv */
// crf_gpr_mem: eight wide general registers with per-access views.
// assumes one write per cycle; reads are registered, zero extended.
module crf_gpr_mem
    import crf_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    crf_gpr_if.mem   gpr
);
    logic [31:0] regs [GPR_COUNT];

    // view extraction, narrow data land in the low bits
    function automatic logic [31:0] view_read(input logic [31:0] w,
                                              input crf_view_t v);
        unique case (v)
            V_LONG:  return w;
            V_UPPER: return {16'h0000, w[31:UPPER_LSB]};
            V_LOWER: return {16'h0000, w[15:0]};
            V_HIGH:  return {24'h00_0000, w[15:HIGH_LSB]};
            default: return {24'h00_0000, w[7:0]};
        endcase
    endfunction : view_read

    // only the lanes of the chosen view change
    function automatic logic [31:0] view_merge(input logic [31:0] w,
                                               input crf_view_t v,
                                               input logic [31:0] d);
        unique case (v)
            V_LONG:  return d;
            V_UPPER: return {d[15:0], w[15:0]};
            V_LOWER: return {w[31:16], d[15:0]};
            V_HIGH:  return {w[31:16], d[7:0], w[7:0]};
            default: return {w[31:8], d[7:0]};
        endcase
    endfunction : view_merge

    // one identical register per entry
    generate
        for (genvar g = 0; g < GPR_COUNT; g++) begin : g_reg
            always_ff @(posedge mclk) begin
                if (!reset_n)
                    regs[g] <= GPR_RESET;
                else if (gpr.wr_en && gpr.wr_idx == 3'(g))
                    regs[g] <= view_merge(regs[g], gpr.wr_view,
                                          gpr.wr_data);
            end
        end
    endgenerate

    // two read ports, each with its own view
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            gpr.rd_a_data <= GPR_RESET;
            gpr.rd_b_data <= GPR_RESET;
        end else begin
            gpr.rd_a_data <= view_read(regs[gpr.rd_a_idx], gpr.rd_a_view);
            gpr.rd_b_data <= view_read(regs[gpr.rd_b_idx], gpr.rd_b_view);
        end
    end

    assign gpr.sp_word = regs[SP_IDX];
endmodule : crf_gpr_mem

/* logic/crf_core.sv */
// crf_core: cpu architectural state - registers, pc, condition flags,
// flag arithmetic and state timing of register operations.
// assumes the execution unit drives one request of each kind per cycle
// and waits for alu_ready before starting an arithmetic operation.
module crf_core
    import crf_pkg::*;
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // reset vector fetch
    output logic              vec_req,
    output logic [15:0]       vec_addr,
    input  wire logic         vec_ack,
    input  wire logic [15:0]  vec_data,
    output logic              cpu_running,
    // program counter
    input  wire logic         pc_inc,
    input  wire logic         pc_load,
    input  wire logic [23:0]  pc_load_val,
    output logic [23:0]       program_counter,
    output logic [15:0]       fetch_addr,
    // general registers
    input  wire logic [2:0]   rd_a_idx,
    input  wire crf_view_t    rd_a_view,
    output logic [31:0]       rd_a_data,
    input  wire logic [2:0]   rd_b_idx,
    input  wire crf_view_t    rd_b_view,
    output logic [31:0]       rd_b_data,
    input  wire logic         wr_en,
    input  wire logic [2:0]   wr_idx,
    input  wire crf_view_t    wr_view,
    input  wire logic [31:0]  wr_data,
    // stack pointer
    input  wire logic         sp_adj_en,
    input  wire logic         sp_adj_dec,
    output logic [31:0]       stack_pointer,
    // condition flags
    input  wire crf_flag_op_t flags_op,
    input  wire logic [7:0]   flags_imm,
    output logic [7:0]        condition_flags,
    output logic              cc_n,
    output logic              cc_z,
    output logic              cc_v,
    output logic              cc_c,
    // arithmetic
    input  wire logic         alu_start,
    input  wire crf_alu_op_t  alu_op,
    input  wire crf_size_t    alu_size,
    input  wire logic [31:0]  op_a,
    input  wire logic [31:0]  op_b,
    output logic              alu_ready,
    output logic              alu_done,
    output logic [31:0]       alu_result,
    // interrupts and exceptions
    input  wire logic         irq_req,
    input  wire logic         nmi_req,
    input  wire logic         exc_start,
    output logic              irq_accept,
    output logic              nmi_accept
);
    crf_gpr_if gpr ();

    crf_state_t   state;
    crf_state_t   next_state;
    logic [7:0]   flags;
    logic [7:0]   next_flags;
    logic [23:0]  pc;
    logic [23:0]  next_pc;
    logic [4:0]   cnt;
    logic         upd_q;
    logic [4:0]   pend_q;
    logic         running;
    logic         vec_take;
    logic         start_ok;

    crf_gpr_mem u_mem (
        .mclk    (mclk),
        .reset_n (reset_n),
        .gpr     (gpr)
    );

    // register file access; a stack adjust takes the write port
    assign gpr.rd_a_idx  = rd_a_idx;
    assign gpr.rd_a_view = rd_a_view;
    assign gpr.rd_b_idx  = rd_b_idx;
    assign gpr.rd_b_view = rd_b_view;
    assign rd_a_data     = gpr.rd_a_data;
    assign rd_b_data     = gpr.rd_b_data;
    assign gpr.wr_en     = wr_en | sp_adj_en;
    assign gpr.wr_idx    = sp_adj_en ? SP_IDX : wr_idx;
    assign gpr.wr_view   = sp_adj_en ? V_LONG : wr_view;
    assign gpr.wr_data   = !sp_adj_en ? wr_data :
                           sp_adj_dec ? gpr.sp_word - SP_STEP :
                                        gpr.sp_word + SP_STEP;
    assign stack_pointer = gpr.sp_word;

    // reset vector handshake and run state
    assign running     = (state == ST_RUN);
    assign cpu_running = running;
    assign vec_req     = (state == ST_VECTOR);
    assign vec_addr    = RESET_VEC;
    assign vec_take    = vec_req && vec_ack;
    assign next_state  = vec_take ? ST_RUN : state;

    always_ff @(posedge mclk) begin
        if (!reset_n)
            state <= ST_VECTOR;
        else
            state <= next_state;
    end

    // pc: vector load, then branch loads and word steps
    assign next_pc = vec_take          ? {8'h00, vec_data} :
                     running & pc_load ? pc_load_val :
                     running & pc_inc  ? pc + PC_STEP : pc;
    assign program_counter = pc;
    // 64-kbyte space, instructions are whole words
    assign fetch_addr = {pc[15:1], 1'b0};

    always_ff @(posedge mclk) begin
        if (!reset_n)
            pc <= PC_RESET;
        else
            pc <= next_pc;
    end

    // adder operand shaping, shared by add, sub, cmp and neg
    logic        is_sub;
    logic        use_x;
    logic        cin;
    logic [31:0] src_a;
    logic [31:0] src_b;
    assign is_sub = alu_op inside {OP_SUB, OP_SUBX, OP_CMP, OP_NEG};
    assign use_x  = alu_op inside {OP_ADDX, OP_SUBX};
    assign src_a  = (alu_op == OP_NEG) ? 32'h0000_0000 : op_a;
    assign src_b  = (alu_op == OP_NEG) ? ~op_a :
                    is_sub ? ~op_b : op_b;
    // subtract is a + ~b + 1, borrow-in removes the +1
    assign cin    = is_sub ? ~(use_x & flags[CCR_C])
                           : (use_x & flags[CCR_C]);

    // partial sums give carries out of bits 3, 11, 27 and the msb
    logic [4:0]  s4;
    logic [8:0]  s8;
    logic [12:0] s12;
    logic [16:0] s16;
    logic [28:0] s28;
    logic [32:0] s32;
    assign s4  = {1'b0, src_a[3:0]} + {1'b0, src_b[3:0]} + {4'h0, cin};
    assign s8  = {1'b0, src_a[7:0]} + {1'b0, src_b[7:0]} + {8'h00, cin};
    assign s12 = {1'b0, src_a[11:0]} + {1'b0, src_b[11:0]}
               + {12'h000, cin};
    assign s16 = {1'b0, src_a[15:0]} + {1'b0, src_b[15:0]}
               + {16'h0000, cin};
    assign s28 = {1'b0, src_a[27:0]} + {1'b0, src_b[27:0]}
               + {28'h000_0000, cin};
    assign s32 = {1'b0, src_a} + {1'b0, src_b} + {32'h0000_0000, cin};

    // size selection of result, carries and sign bits
    logic [31:0] add_res;
    logic        hc;
    logic        cy;
    logic        sa;
    logic        sb;
    logic        sr;
    always_comb begin
        unique case (alu_size)
            SZ_BYTE: begin
                add_res = {24'h00_0000, s8[7:0]};
                hc = s4[4];
                cy = s8[8];
                sa = src_a[7];
                sb = src_b[7];
                sr = s8[7];
            end
            SZ_WORD: begin
                add_res = {16'h0000, s16[15:0]};
                hc = s12[12];
                cy = s16[16];
                sa = src_a[15];
                sb = src_b[15];
                sr = s16[15];
            end
            default: begin
                add_res = s32[31:0];
                hc = s28[28];
                cy = s32[32];
                sa = src_a[31];
                sb = src_b[31];
                sr = s32[31];
            end
        endcase
    end

    // flags of the result: {h, n, z, v, c}; borrow is inverted carry
    logic       res_zero;
    logic [4:0] arith_flags;
    assign res_zero    = (add_res == 32'h0000_0000);
    assign arith_flags = {
        hc ^ is_sub,
        sr,
        use_x ? (flags[CCR_Z] & res_zero) : res_zero,
        (sa == sb) && (sr != sa),
        cy ^ is_sub
    };

    // multiply and divide, unsigned; remainder in the upper part
    logic [15:0] mul8;
    logic [15:0] q8;
    logic [15:0] r8;
    logic [31:0] mul16;
    logic [31:0] q16;
    logic [31:0] r16;
    logic        dz8;
    logic        dz16;
    assign dz8   = (op_b[7:0] == 8'h00);
    assign dz16  = (op_b[15:0] == 16'h0000);
    assign mul8  = 16'(op_a[7:0]) * 16'(op_b[7:0]);
    assign mul16 = 32'(op_a[15:0]) * 32'(op_b[15:0]);
    // a zero divisor gives all ones rather than an undefined value
    assign q8    = dz8  ? 16'hffff : op_a[15:0] / {8'h00, op_b[7:0]};
    assign r8    = dz8  ? 16'hffff : op_a[15:0] % {8'h00, op_b[7:0]};
    assign q16   = dz16 ? 32'hffff_ffff : op_a / {16'h0000, op_b[15:0]};
    assign r16   = dz16 ? 32'hffff_ffff : op_a % {16'h0000, op_b[15:0]};

    // result, state count and flag update chosen by operation
    logic [31:0] next_res;
    logic [4:0]  next_cnt;
    logic        next_upd;
    always_comb begin
        unique case (alu_op)
            OP_MUL8: begin
                next_res = {16'h0000, mul8};
                next_cnt = CNT_MD_S;
                next_upd = 1'b0;
            end
            OP_DIV8: begin
                next_res = {16'h0000, r8[7:0], q8[7:0]};
                next_cnt = CNT_MD_S;
                next_upd = 1'b0;
            end
            OP_MUL16: begin
                next_res = mul16;
                next_cnt = CNT_MD_L;
                next_upd = 1'b0;
            end
            OP_DIV16: begin
                next_res = {r16[15:0], q16[15:0]};
                next_cnt = CNT_MD_L;
                next_upd = 1'b0;
            end
            default: begin
                next_res = add_res;
                next_cnt = CNT_ADDSUB;
                next_upd = 1'b1;
            end
        endcase
    end

    // operation timing: start counts as the first state
    assign alu_ready = running && (cnt == 5'h00);
    assign start_ok  = alu_start && alu_ready;
    assign alu_done  = (cnt == 5'h01);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt        <= 5'h00;
            upd_q      <= 1'b0;
            pend_q     <= 5'h00;
            alu_result <= 32'h0000_0000;
        end else if (start_ok) begin
            cnt        <= next_cnt;
            upd_q      <= next_upd;
            pend_q     <= arith_flags;
            alu_result <= next_res;
        end else if (cnt != 5'h00) begin
            cnt        <= cnt - 5'h01;
        end
    end

    // flag update: arithmetic, then flag ops, then mask set on top
    always_comb begin
        next_flags = flags;
        if (alu_done && upd_q) begin
            // user bits and mask are not touched by arithmetic
            next_flags[CCR_H] = pend_q[4];
            next_flags[CCR_N] = pend_q[3];
            next_flags[CCR_Z] = pend_q[2];
            next_flags[CCR_V] = pend_q[1];
            next_flags[CCR_C] = pend_q[0];
        end
        unique case (flags_op)
            LOAD_FLAGS_OP: next_flags = flags_imm;
            AND_FLAGS_OP:  next_flags = flags & flags_imm;
            OR_FLAGS_OP:   next_flags = flags | flags_imm;
            XOR_FLAGS_OP:  next_flags = flags ^ flags_imm;
            default:       next_flags = next_flags;
        endcase
        if (exc_start)
            next_flags[CCR_I] = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n)
            flags <= CCR_RESET;
        else
            flags <= next_flags;
    end

    // stored flags read straight out; branch conditions from them
    assign condition_flags = flags;
    assign cc_n = flags[CCR_N];
    assign cc_z = flags[CCR_Z];
    assign cc_v = flags[CCR_V];
    assign cc_c = flags[CCR_C];

    // mask gates ordinary requests only
    assign irq_accept = running && irq_req && !flags[CCR_I];
    assign nmi_accept = running && nmi_req;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic nib_c;
    assign nib_c = s4[4];

    sequence s_quiet12;
        !alu_done [*8] ##1 !alu_done [*4];
    endsequence

    a_reset_mask: assert property (
        @(posedge mclk) disable iff (1'b0)
        !reset_n |=> flags[CCR_I] && vec_req)
        else $error("mask not set after reset");
    a_exc_mask: assert property (
        exc_start |=> flags[CCR_I])
        else $error("mask not set on exception");
    a_irq_gate: assert property (
        (irq_accept |-> !flags[CCR_I]) and (nmi_req && running |-> nmi_accept))
        else $error("interrupt gating wrong");
    a_fetch_even: assert property (
        pc_load && running |=> !fetch_addr[0] &&
        fetch_addr[15:1] == $past(pc_load_val[15:1]))
        else $error("fetch address wrong");
    a_vector_load: assert property (
        vec_take |=> running && pc == {8'h00, $past(vec_data)})
        else $error("pc not loaded from vector");
    a_addsub_time: assert property (
        start_ok && next_upd |=> alu_done ##1 !alu_done && alu_ready)
        else $error("add or subtract not two states");
    a_mul_short: assert property (
        start_ok && alu_op inside {OP_MUL8, OP_DIV8}
        |=> s_quiet12 ##1 alu_done)
        else $error("short multiply or divide not 14 states");
    a_mul_long: assert property (
        start_ok && alu_op inside {OP_MUL16, OP_DIV16}
        |-> ##21 alu_done)
        else $error("long multiply or divide not 22 states");
    a_half_byte: assert property (
        start_ok && alu_op == OP_ADD && alu_size == SZ_BYTE
        ##1 (flags_op == FLAGS_KEEP)
        |=> flags[CCR_H] == $past(nib_c, 2))
        else $error("byte half carry wrong");
    a_user_keep: assert property (
        flags_op == FLAGS_KEEP |=> flags[CCR_UI] == $past(flags[CCR_UI])
        && flags[CCR_U] == $past(flags[CCR_U]))
        else $error("user bit changed by hardware");
    a_sp_step: assert property (
        sp_adj_en && sp_adj_dec |=>
        stack_pointer == $past(stack_pointer) - SP_STEP)
        else $error("stack pointer not stepped");
endmodule : crf_core

/* verif/crf_vec_model.sv */
// crf_vec_model: execution side that answers the reset vector fetch.
// assumes requests are seen on falling mclk; answers after DELAY cycles.
module crf_vec_model #(
    parameter int          DELAY = 3,
    parameter logic [15:0] START = 16'h1234
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // vector fetch
    input  wire logic        vec_req,
    input  wire logic [15:0] vec_addr,
    output logic             vec_ack,
    output logic [15:0]      vec_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt;
    // slow answer on purpose; data is garbage while not acknowledged
    always @(negedge mclk) begin
        if (!reset_n || !vec_req) begin
            wait_cnt = 0;
            vec_ack  = 1'b0;
        end else if (wait_cnt < DELAY) begin
            wait_cnt++;
        end else begin
            vec_ack = 1'b1;
        end
        vec_data = vec_ack ? START : ~START;
    end
endmodule : crf_vec_model

/* verif/cpu_register_file_ccr_tb.sv */
// cpu_register_file_ccr_tb: self-checking bench of crf_core.
// assumes inputs change on falling mclk; vector model answers start.
module cpu_register_file_ccr_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;
    logic        mclk = 1'b0, reset_n = 1'b0;
    logic        vec_req, vec_ack, cpu_running, pc_inc, pc_load;
    logic        wr_en, sp_adj_en, sp_adj_dec, alu_start, alu_ready;
    logic        alu_done, irq_req, nmi_req, exc_start, irq_accept;
    logic        nmi_accept, cc_n, cc_z, cc_v, cc_c;
    logic [2:0]  rd_a_idx, rd_b_idx, wr_idx;
    logic [7:0]  flags_imm, condition_flags;
    logic [15:0] vec_addr, vec_data, fetch_addr;
    logic [23:0] pc_load_val, program_counter;
    logic [31:0] rd_a_data, rd_b_data, wr_data, stack_pointer;
    logic [31:0] op_a, op_b, alu_result;
    crf_view_t    rd_a_view, rd_b_view, wr_view;
    crf_flag_op_t flags_op;
    crf_alu_op_t  alu_op;
    crf_size_t    alu_size;
    int          n_mismatch = 0, comparisons = 0;
    crf_core u_dut (
        .mclk, .reset_n, .vec_req, .vec_addr, .vec_ack, .vec_data,
        .cpu_running, .pc_inc, .pc_load, .pc_load_val, .program_counter,
        .fetch_addr, .rd_a_idx, .rd_a_view, .rd_a_data, .rd_b_idx,
        .rd_b_view, .rd_b_data, .wr_en, .wr_idx, .wr_view, .wr_data,
        .sp_adj_en, .sp_adj_dec, .stack_pointer, .flags_op, .flags_imm,
        .condition_flags, .cc_n, .cc_z, .cc_v, .cc_c, .alu_start, .alu_op,
        .alu_size, .op_a, .op_b, .alu_ready, .alu_done, .alu_result,
        .irq_req, .nmi_req, .exc_start, .irq_accept, .nmi_accept
    );
    crf_vec_model u_vec (.mclk, .reset_n, .vec_req, .vec_addr, .vec_ack,
        .vec_data);
    // free-running 100 MHz clock
    always #5 mclk = ~mclk;
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [2:0] i, input crf_view_t v,
                      input logic [31:0] d);
        wr_idx  = i;
        wr_view = v;
        wr_data = d;
        wr_en   = 1'b1;
        @(negedge mclk);
        wr_en     = 1'b0;
        sp_adj_en = 1'b0;
        // idle cycle keeps back-to-back strobes apart
        @(negedge mclk);
    endtask : wr
    // both read ports at once, data one cycle later
    task automatic rd(input logic [2:0] ia, ib, input crf_view_t va, vb);
        rd_a_idx = ia; rd_a_view = va; rd_b_idx = ib; rd_b_view = vb;
        @(negedge mclk);
    endtask : rd
    task automatic fl(input crf_flag_op_t op, input logic [7:0] imm, exp);
        flags_op  = op;
        flags_imm = imm;
        @(negedge mclk);
        flags_op = FLAGS_KEEP;
        chk("flags", exp, condition_flags);
        @(negedge mclk);
    endtask : fl
    // flags given as {h, n, z, v, c}
    task automatic alu(input crf_alu_op_t op, input crf_size_t sz,
        input logic [31:0] a, b, m, res, input int n, input logic [4:0] f);
        int k;
        alu_op = op; alu_size = sz; op_a = a; op_b = b; alu_start = 1'b1;
        @(negedge mclk);
        alu_start = 1'b0;
        for (k = 1; k < 30 && alu_done !== 1'b1; k++) @(negedge mclk);
        chk("done cycle", 32'(n - 1), 32'(k));
        chk("result", res, alu_result & m);
        @(negedge mclk);
        chk("hnzvc", f,
            {condition_flags[CCR_H], condition_flags[3:0]});
        chk("ready", 32'h1, alu_ready);
    endtask : alu
    task automatic t_vector;
        for (int i = 0; i < 20 && cpu_running !== 1'b1; i++)
            @(negedge mclk);
        chk("pc start", 24'h001234, program_counter);
        chk("flags reset", CCR_RESET, condition_flags);
        chk("running", 32'h1, cpu_running);
        chk("vec req", 32'h0, vec_req);
        chk("vec addr", RESET_VEC, vec_addr);
    endtask : t_vector
    task automatic t_pc;
        pc_inc = 1'b1;
        @(negedge mclk);
        chk("pc step", 24'h001236, program_counter);
        // pc_inc stays up, the load must win over it
        pc_load_val = 24'h12abcd;
        pc_load     = 1'b1;
        @(negedge mclk);
        pc_load = 1'b0;
        pc_inc  = 1'b0;
        chk("pc load", 24'h12abcd, program_counter);
        chk("fetch", 16'habcc, fetch_addr);
    endtask : t_pc
    task automatic t_gpr;
        for (int i = 0; i < 8; i++)
            wr(3'(i), V_LONG, 32'h01010101 * i);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), 3'(i), V_LONG, V_LOW);
            chk("gpr long", 32'h01010101 * i, rd_a_data);
        end
        chk("sp", 32'h07070707, stack_pointer);
        // the write request beside it must lose to the stack adjust
        sp_adj_en  = 1'b1;
        sp_adj_dec = 1'b1;
        wr(3'h7, V_LONG, 32'h0);
        chk("sp dec", 32'h07070705, stack_pointer);
        sp_adj_en  = 1'b1;
        sp_adj_dec = 1'b0;
        wr(3'h7, V_LONG, 32'h0);
        chk("sp inc", 32'h07070707, stack_pointer);
        wr(3'h3, V_HIGH, 32'h000000aa);
        wr(3'h3, V_UPPER, 32'h0000beef);
        rd(3'h3, 3'h3, V_LONG, V_LOW);
        chk("long", 32'hbeefaa03, rd_a_data);
        chk("low", 32'h00000003, rd_b_data);
        rd(3'h3, 3'h3, V_UPPER, V_HIGH);
        chk("upper", 32'h0000beef, rd_a_data);
        chk("high", 32'h000000aa, rd_b_data);
        rd(3'h3, 3'h2, V_LOWER, V_LOWER);
        chk("lower", 32'h0000aa03, rd_a_data);
        chk("other", 32'h00000202, rd_b_data);
        wr(3'h2, V_LOWER, 32'hffff5566);
        wr(3'h2, V_LOW, 32'hffffff77);
        rd(3'h2, 3'h2, V_LONG, V_LOW);
        chk("lower write", 32'h02025577, rd_a_data);
        chk("low write", 32'h00000077, rd_b_data);
    endtask : t_gpr
    task automatic t_flags;
        fl(LOAD_FLAGS_OP, 8'h50, 8'h50);
        fl(OR_FLAGS_OP, 8'h0f, 8'h5f);
        chk("cond", 4'hf, {cc_n, cc_z, cc_v, cc_c});
        fl(AND_FLAGS_OP, 8'hf5, 8'h55);
        fl(XOR_FLAGS_OP, 8'hff, 8'haa);
        chk("cond", 4'ha, {cc_n, cc_z, cc_v, cc_c});
    endtask : t_flags
    task automatic t_alu;
        alu(OP_ADD, SZ_BYTE, 32'h08, 32'h08, 32'hff, 32'h10, 2, 5'h10);
        alu(OP_ADD, SZ_BYTE, 32'h07, 32'h01, 32'hff, 32'h08, 2, 5'h00);
        alu(OP_ADD, SZ_BYTE, 32'hff, 32'h01, 32'hff, 32'h00, 2, 5'h15);
        alu(OP_ADD, SZ_BYTE, 32'h7f, 32'h01, 32'hff, 32'h80, 2, 5'h1a);
        alu(OP_ADD, SZ_WORD, 32'h0800, 32'h0800, 32'hffff, 32'h1000, 2,
            5'h10);
        alu(OP_SUB, SZ_LONG, 32'h10000000, 32'h1, '1, 32'h0fffffff, 2,
            5'h10);
        alu(OP_MUL8, SZ_BYTE, 32'h0c, 32'h0b, 32'hffff, 32'h84, 14,
            5'h10);
        alu(OP_DIV16, SZ_WORD, 32'h64, 32'h07, '1, 32'h0002000e, 22,
            5'h10);
        // zero minus one borrows at both the nibble and the msb
        alu(OP_NEG, SZ_BYTE, 32'h01, 32'h00, 32'hff, 32'hff, 2,
            5'h19);
        alu(OP_ADDX, SZ_BYTE, 32'h10, 32'h0f, 32'hff, 32'h20, 2,
            5'h10);
        alu(OP_CMP, SZ_WORD, 32'h1234, 32'h1234, 32'hffff, 32'h0000, 2,
            5'h04);
    endtask : t_alu
    task automatic t_irq;
        irq_req = 1'b1;
        nmi_req = 1'b1;
        fl(LOAD_FLAGS_OP, 8'h80, 8'h80);
        chk("irq masked", 0, irq_accept);
        chk("nmi", 1, nmi_accept);
        fl(LOAD_FLAGS_OP, 8'h00, 8'h00);
        chk("irq open", 1, irq_accept);
        exc_start = 1'b1;
        @(negedge mclk);
        exc_start = 1'b0;
        chk("exc mask", 8'h80, condition_flags);
        chk("irq after", 0, irq_accept);
    endtask : t_irq
    // all inputs defined at time zero, reset for three cycles
    initial begin
        {pc_inc, pc_load, wr_en, sp_adj_en, sp_adj_dec} = '0;
        {alu_start, irq_req, nmi_req, exc_start} = '0;
        {rd_a_idx, rd_b_idx, wr_idx, flags_imm} = '0;
        {pc_load_val, wr_data, op_a, op_b} = '0;
        rd_a_view = V_LONG;
        rd_b_view = V_LONG;
        wr_view   = V_LONG;
        flags_op  = FLAGS_KEEP;
        alu_op    = OP_ADD;
        alu_size  = SZ_BYTE;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        t_vector;
        t_pc;
        t_gpr;
        t_flags;
        t_alu;
        t_irq;
        finish_test;
    end
    // watchdog, about seventeen times the expected run
    initial begin
        #20000;
        n_mismatch++;
        finish_test;
    end
endmodule : cpu_register_file_ccr_tb
